// ===== hw/cafl_top.sv
`timescale 1ns/1ps
module cafl_top import cafl_pkg::*; (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   input wire logic conv_done_in,
   input wire logic [RES_W-1:0] conv_result_in,
   input wire logic supply_low_cmp_in,
   input wire logic supply_high_cmp_in,
   input wire logic conversion_start_select_n_in,
   output logic shared_alarm_output_pin_out,
   output logic shared_alarm_output_pin_oe_n_out,
   output logic [FLAG_W-1:0] frame_alarm_flags_out,
   output logic [RES_W+SEL_W-1:0] stream_data_out,
   output logic stream_valid_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] pin_sel_q;
   logic input_alarm_disable_q;
   logic supply_alarm_disable_q;
   logic [RES_W-1:0] high_th_q;
   logic [RES_W-1:0] low_th_q;
   logic [HYS_W-1:0] hyst_q;
   logic fmt_append_q;
   logic [SEL_W-1:0] fmt_sel_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [DATA_W-1:0] rdata_q;

   logic in_act_q;
   logic in_trip_q;
   logic sup_act_q;
   logic sup_trip_q;
   logic in_high_q;
   logic in_low_q;

   logic cs_s1_q;
   logic cs_s2_q;
   logic cs_s3_q;
   logic sl_s1_q;
   logic sl_s2_q;
   logic sl_s3_q;
   logic sh_s1_q;
   logic sh_s2_q;
   logic sh_s3_q;
   logic sup_cross_q;

   logic [RES_W-1:0] result_q;
   logic eoc_q;
   logic [FLAG_W-1:0] frame_flags_q;
   logic [RES_W+SEL_W-1:0] stream_data_q;
   logic stream_valid_q;

   logic hc_high_next;
   logic hc_low_next;
   logic in_cond;
   logic sup_cond;
   logic sup_edge;
   logic frame_start;
   logic wr_pin;
   logic wr_rpc;
   logic wr_hth;
   logic wr_lth;
   logic wr_hys;
   logic wr_fmt;
   logic wr_istat;
   logic wr_imask;
   logic rd_flags;
   logic pin_is_alarm;
   logic [FLAG_W-1:0] flags_now;
   logic [SEL_W-1:0] stream_flags;
   logic [DATA_W-1:0] rdata_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   assign wr_pin = reg_wr_in && (reg_addr_in == OFF_PIN_CTL);
   assign wr_rpc = reg_wr_in && (reg_addr_in == OFF_RST_PWR);
   assign wr_hth = reg_wr_in && (reg_addr_in == OFF_HIGH_TH);
   assign wr_lth = reg_wr_in && (reg_addr_in == OFF_LOW_TH);
   assign wr_hys = reg_wr_in && (reg_addr_in == OFF_HYST);
   assign wr_fmt = reg_wr_in && (reg_addr_in == OFF_FMT_CTL);
   assign wr_istat = reg_wr_in && (reg_addr_in == OFF_IRQ_STAT);
   assign wr_imask = reg_wr_in && (reg_addr_in == OFF_IRQ_MASK);
   assign rd_flags = reg_rd_in && (reg_addr_in == OFF_FLAGS);

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_sel_q <= RST_PIN_SEL;
      end else if (wr_pin) begin
         pin_sel_q <= reg_wdata_in[PIN_SEL_LSB+:2];
      end
   end

   // Zero at reset: both alarms run
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         input_alarm_disable_q <= RST_DIS[RPC_IN_DIS_BIT];
         supply_alarm_disable_q <= RST_DIS[RPC_SUP_DIS_BIT];
      end else if (wr_rpc) begin
         input_alarm_disable_q <= reg_wdata_in[RPC_IN_DIS_BIT];
         supply_alarm_disable_q <= reg_wdata_in[RPC_SUP_DIS_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         high_th_q <= RST_HIGH_TH;
         low_th_q <= RST_LOW_TH;
         hyst_q <= RST_HYST;
      end else begin
         if (wr_hth) begin
            high_th_q <= reg_wdata_in[RES_W-1:0];
         end
         if (wr_lth) begin
            low_th_q <= reg_wdata_in[RES_W-1:0];
         end
         if (wr_hys) begin
            hyst_q <= reg_wdata_in[HYS_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fmt_append_q <= RST_FMT[FMT_APPEND_BIT];
         fmt_sel_q <= RST_FMT[FMT_SEL_LSB+:SEL_W];
      end else if (wr_fmt) begin
         fmt_append_q <= reg_wdata_in[FMT_APPEND_BIT];
         fmt_sel_q <= reg_wdata_in[FMT_SEL_LSB+:SEL_W];
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_mask_q <= RST_IRQ_MASK;
      end else if (wr_imask) begin
         irq_mask_q <= reg_wdata_in[IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Asynchronous pins
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         sl_s1_q <= 1'b0;
         sl_s2_q <= 1'b0;
         sl_s3_q <= 1'b0;
         sh_s1_q <= 1'b0;
         sh_s2_q <= 1'b0;
         sh_s3_q <= 1'b0;
      end else begin
         cs_s1_q <= conversion_start_select_n_in;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         sl_s1_q <= supply_low_cmp_in;
         sl_s2_q <= sl_s1_q;
         sl_s3_q <= sl_s2_q;
         sh_s1_q <= supply_high_cmp_in;
         sh_s2_q <= sh_s1_q;
         sh_s3_q <= sh_s2_q;
      end
   end

   assign frame_start = cs_s3_q && !cs_s2_q;
   assign sup_edge = (sl_s2_q != sl_s3_q) || (sh_s2_q != sh_s3_q);

   // Glitch between conversions held for the next
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sup_cross_q <= 1'b0;
      end else if (sup_edge) begin
         sup_cross_q <= 1'b1;
      end else if (conv_done_in) begin
         sup_cross_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm conditions
   cafl_hyst_cmp u_hyst (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .update_in(conv_done_in),
      .result_in(conv_result_in),
      .high_th_in(high_th_q),
      .low_th_in(low_th_q),
      .hyst_in(hyst_q),
      .high_next_out(hc_high_next),
      .low_next_out(hc_low_next)
   );

   assign in_cond = (hc_high_next || hc_low_next) && !input_alarm_disable_q;
   assign sup_cond = (sl_s2_q || sh_s2_q || sup_cross_q) && !supply_alarm_disable_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Flags
   // Rebuilt each conversion
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         in_act_q <= 1'b0;
         sup_act_q <= 1'b0;
         in_high_q <= 1'b0;
         in_low_q <= 1'b0;
      end else if (conv_done_in) begin
         in_act_q <= in_cond;
         sup_act_q <= sup_cond;
         in_high_q <= hc_high_next && !input_alarm_disable_q;
         in_low_q <= hc_low_next && !input_alarm_disable_q;
      end
   end

   // Set wins over read clear
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         in_trip_q <= 1'b0;
         sup_trip_q <= 1'b0;
      end else begin
         if (conv_done_in && in_cond) begin
            in_trip_q <= 1'b1;
         end else if (rd_flags) begin
            in_trip_q <= 1'b0;
         end
         if (conv_done_in && sup_cond) begin
            sup_trip_q <= 1'b1;
         end else if (rd_flags) begin
            sup_trip_q <= 1'b0;
         end
      end
   end

   assign flags_now = cafl_pack_flags(in_trip_q, in_act_q, sup_trip_q, sup_act_q,
                                      in_high_q, in_low_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Frame snapshot and output stream
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         frame_flags_q <= '0;
      end else if (frame_start) begin
         frame_flags_q <= flags_now;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         result_q <= '0;
         eoc_q <= 1'b0;
      end else begin
         eoc_q <= conv_done_in;
         if (conv_done_in) begin
            result_q <= conv_result_in;
         end
      end
   end

   // One cycle late to carry fresh flags
   assign stream_flags = fmt_append_q ? (flags_now[SEL_W-1:0] & fmt_sel_q) : '0;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stream_data_q <= '0;
         stream_valid_q <= 1'b0;
      end else begin
         stream_valid_q <= eoc_q;
         if (eoc_q) begin
            stream_data_q <= {result_q, stream_flags};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_stat_q <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if (conv_done_in && ((i == IRQ_IN_BIT) ? in_cond : sup_cond)) begin
               irq_stat_q[i] <= 1'b1;
            end else if (wr_istat && reg_wdata_in[i]) begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Shared pin
   // Released in other functions
   assign pin_is_alarm = (pin_sel_q == PIN_SEL_ALARM);
   assign shared_alarm_output_pin_oe_n_out = !pin_is_alarm;
   assign shared_alarm_output_pin_out = pin_is_alarm && (in_act_q || sup_act_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   always_comb begin
      rdata_d = '0;
      if (reg_addr_in == OFF_PIN_CTL) begin
         rdata_d[PIN_SEL_LSB+:2] = pin_sel_q;
      end else if (reg_addr_in == OFF_RST_PWR) begin
         rdata_d[RPC_IN_DIS_BIT] = input_alarm_disable_q;
         rdata_d[RPC_SUP_DIS_BIT] = supply_alarm_disable_q;
      end else if (reg_addr_in == OFF_HIGH_TH) begin
         rdata_d[RES_W-1:0] = high_th_q;
      end else if (reg_addr_in == OFF_LOW_TH) begin
         rdata_d[RES_W-1:0] = low_th_q;
      end else if (reg_addr_in == OFF_HYST) begin
         rdata_d[HYS_W-1:0] = hyst_q;
      end else if (reg_addr_in == OFF_FMT_CTL) begin
         rdata_d[FMT_APPEND_BIT] = fmt_append_q;
         rdata_d[FMT_SEL_LSB+:SEL_W] = fmt_sel_q;
      end else if (reg_addr_in == OFF_FLAGS) begin
         rdata_d[FLAG_W-1:0] = flags_now;
      end else if (reg_addr_in == OFF_IRQ_STAT) begin
         rdata_d[IRQ_W-1:0] = irq_stat_q;
      end else if (reg_addr_in == OFF_IRQ_MASK) begin
         rdata_d[IRQ_W-1:0] = irq_mask_q;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_q <= '0;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign frame_alarm_flags_out = frame_flags_q;
   assign stream_data_out = stream_data_q;
   assign stream_valid_out = stream_valid_q;
endmodule

// ===== hw/cafl_pkg.sv
// How it works
// - The pin carries the alarm level only while its select field holds 01b.
// - The input alarm compares each result with programmable high and low thresholds.
// - The supply alarm follows the 4.7 V and 5.3 V comparators, crossing either way.
// - Both alarms are enabled out of reset.
// - Separate disable bits suppress the input and the supply alarm.
// - Each alarm has active and tripped flags, all readable in the flag register.
// - A detected alarm sets its active and tripped flags together.
// - Active flags are rebuilt at each end of conversion.
// - Tripped flags hold until the flag register is read.
// - Flags change only at the end of a conversion, and tripped flags also when the flag register is read.
// - A frame opened by a low select gets the current flags.
// - The pin goes high for a supply or input alarm.
// - Selected flags may be appended to the output data word.
// - The high alarm sets above T and releases at T minus H minus 1 or below.
// - The low alarm sets below T and releases at T plus H plus 1 or above.
package cafl_pkg;
   localparam int unsigned RES_W = 18;
   localparam int unsigned HYS_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FLAG_W = 6;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned CMP_W = 20;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_PIN_CTL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RST_PWR = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_HIGH_TH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_LOW_TH = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_HYST = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_FMT_CTL = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;

   // Field positions
   localparam int unsigned PIN_SEL_LSB = 0;
   localparam logic [1:0] PIN_SEL_ALARM = 2'h1;
   localparam int unsigned RPC_IN_DIS_BIT = 0;
   localparam int unsigned RPC_SUP_DIS_BIT = 1;
   localparam int unsigned FMT_APPEND_BIT = 0;
   localparam int unsigned FMT_SEL_LSB = 1;
   localparam int unsigned FLG_IN_TRIP = 0;
   localparam int unsigned FLG_IN_ACT = 1;
   localparam int unsigned FLG_SUP_TRIP = 2;
   localparam int unsigned FLG_SUP_ACT = 3;
   localparam int unsigned FLG_IN_HIGH = 4;
   localparam int unsigned FLG_IN_LOW = 5;
   localparam int unsigned IRQ_IN_BIT = 0;
   localparam int unsigned IRQ_SUP_BIT = 1;

   // Reset values
   localparam logic [1:0] RST_PIN_SEL = 2'h0;
   localparam logic [1:0] RST_DIS = 2'h0;
   localparam logic [RES_W-1:0] RST_HIGH_TH = 18'h3_ffff;
   localparam logic [RES_W-1:0] RST_LOW_TH = 18'h0_0000;
   localparam logic [HYS_W-1:0] RST_HYST = 8'h00;
   localparam logic [SEL_W:0] RST_FMT = 5'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

   function automatic logic [FLAG_W-1:0] cafl_pack_flags(input logic in_trip,
      input logic in_act,
      input logic sup_trip,
      input logic sup_act,
      input logic in_high,
      input logic in_low);
      logic [FLAG_W-1:0] f;
      f = '0;
      f[FLG_IN_TRIP] = in_trip;
      f[FLG_IN_ACT] = in_act;
      f[FLG_SUP_TRIP] = sup_trip;
      f[FLG_SUP_ACT] = sup_act;
      f[FLG_IN_HIGH] = in_high;
      f[FLG_IN_LOW] = in_low;
      return f;
   endfunction
endpackage

// ===== hw/cafl_hyst_cmp.sv
`timescale 1ns/1ps
module cafl_hyst_cmp import cafl_pkg::*; (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic update_in,
   input wire logic [RES_W-1:0] result_in,
   input wire logic [RES_W-1:0] high_th_in,
   input wire logic [RES_W-1:0] low_th_in,
   input wire logic [HYS_W-1:0] hyst_in,
   output logic high_next_out,
   output logic low_next_out
);
   logic high_q;
   logic low_q;
   logic [CMP_W-1:0] res_x;
   logic [CMP_W-1:0] res_hys;
   logic [CMP_W-1:0] hi_x;
   logic [CMP_W-1:0] lo_hys;

   // Widened so sums never wrap
   assign res_x = {2'b00, result_in};
   assign res_hys = res_x + {12'h000, hyst_in} + 20'h0_0001;
   assign hi_x = {2'b00, high_th_in};
   assign lo_hys = {2'b00, low_th_in} + {12'h000, hyst_in} + 20'h0_0001;

   always_comb begin
      high_next_out = high_q;
      if (res_x > hi_x) begin
         high_next_out = 1'b1;
      end else if (res_hys <= hi_x) begin
         high_next_out = 1'b0;
      end
      low_next_out = low_q;
      if (result_in < low_th_in) begin
         low_next_out = 1'b1;
      end else if (res_x >= lo_hys) begin
         low_next_out = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         high_q <= 1'b0;
         low_q <= 1'b0;
      end else if (update_in) begin
         high_q <= high_next_out;
         low_q <= low_next_out;
      end
   end
endmodule

// ===== verif/cafl_top_asserts.sv
`timescale 1ns/1ps
module cafl_top_asserts import cafl_pkg::*; (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [DATA_W-1:0] reg_rdata_out,
   input wire logic conv_done_in,
   input wire logic [RES_W-1:0] conv_result_in,
   input wire logic supply_low_cmp_in,
   input wire logic supply_high_cmp_in,
   input wire logic conversion_start_select_n_in,
   input wire logic shared_alarm_output_pin_out,
   input wire logic shared_alarm_output_pin_oe_n_out,
   input wire logic [FLAG_W-1:0] frame_alarm_flags_out,
   input wire logic stream_valid_out,
   input wire logic irq_out
);
   logic [1:0] sel_q;
   logic [1:0] dis_q;
   logic [RES_W-1:0] hi_q;
   logic [RES_W-1:0] lo_q;
   logic [IRQ_W-1:0] mask_q;
   logic sel_ok;
   assign sel_ok = (sel_q == PIN_SEL_ALARM);
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_q <= RST_PIN_SEL;
         dis_q <= RST_DIS;
         hi_q <= RST_HIGH_TH;
         lo_q <= RST_LOW_TH;
         mask_q <= RST_IRQ_MASK;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            OFF_PIN_CTL: sel_q <= reg_wdata_in[1:0];
            OFF_RST_PWR: dis_q <= reg_wdata_in[1:0];
            OFF_HIGH_TH: hi_q <= reg_wdata_in[RES_W-1:0];
            OFF_LOW_TH: lo_q <= reg_wdata_in[RES_W-1:0];
            OFF_IRQ_MASK: mask_q <= reg_wdata_in[IRQ_W-1:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////
   sequence s_flag_rd;
      reg_rd_in && reg_addr_in == OFF_FLAGS && !conv_done_in;
   endsequence
   sequence s_supply_out;
      (supply_low_cmp_in || supply_high_cmp_in) [*4];
   endsequence
   property p_rd_idle; !reg_rd_in |=> reg_rdata_out == '0; endproperty
   property p_rd_clear;
      s_flag_rd ##1 !conv_done_in ##1 s_flag_rd |=>
         !reg_rdata_out[FLG_IN_TRIP] && !reg_rdata_out[FLG_SUP_TRIP];
   endproperty
   // Checked once select settles
   property p_oe;
      sel_q == $past(sel_q) |-> shared_alarm_output_pin_oe_n_out == !sel_ok;
   endproperty
   property p_pin_off; !sel_ok |-> !shared_alarm_output_pin_out; endproperty
   property p_pin_quiet;
      !conv_done_in && !(reg_wr_in && reg_addr_in == OFF_PIN_CTL) |=>
         $stable(shared_alarm_output_pin_out);
   endproperty
   property p_high;
      conv_done_in && sel_ok && !dis_q[RPC_IN_DIS_BIT] && conv_result_in > hi_q
         |=> shared_alarm_output_pin_out;
   endproperty
   property p_low;
      conv_done_in && sel_ok && !dis_q[RPC_IN_DIS_BIT] && conv_result_in < lo_q
         |=> shared_alarm_output_pin_out;
   endproperty
   property p_supply;
      s_supply_out ##0 (conv_done_in && sel_ok && !dis_q[RPC_SUP_DIS_BIT])
         |=> shared_alarm_output_pin_out;
   endproperty
   property p_stream; conv_done_in |-> ##2 stream_valid_out; endproperty
   property p_stream_src; stream_valid_out |-> $past(conv_done_in, 2); endproperty
   property p_frame;
      $changed(frame_alarm_flags_out) |->
         !$past(conversion_start_select_n_in, 2) && $past(conversion_start_select_n_in, 6);
   endproperty
   property p_irq_mask;
      mask_q == '0 && $past(mask_q) == '0 |-> !irq_out;
   endproperty
   property p_irq_w1c;
      reg_wr_in && reg_addr_in == OFF_IRQ_STAT && reg_wdata_in[1:0] == 2'h3 &&
         !conv_done_in ##1 !conv_done_in |=> !irq_out;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("idle rdata");
   a_rd_clear: assert property (p_rd_clear) else $error("trip kept");
   a_oe: assert property (p_oe) else $error("oe select");
   a_pin_off: assert property (p_pin_off) else $error("pin unselected");
   a_pin_quiet: assert property (p_pin_quiet) else $error("pin moved");
   a_high: assert property (p_high) else $error("high miss");
   a_low: assert property (p_low) else $error("low miss");
   a_supply: assert property (p_supply) else $error("supply miss");
   a_stream: assert property (p_stream) else $error("no stream");
   a_stream_src: assert property (p_stream_src) else $error("stray stream");
   a_frame: assert property (p_frame) else $error("frame flags");
   a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
   a_irq_w1c: assert property (p_irq_w1c) else $error("irq kept");
endmodule

bind cafl_top cafl_top_asserts u_cafl_top_asserts (.*);

// ===== verif/cafl_host_model.sv
`timescale 1ns/1ps
module cafl_host_model import cafl_pkg::*; (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic frame_req_in,
   input wire logic [3:0] hold_in,
   input wire logic [FLAG_W-1:0] frame_flags_in,
   output logic select_n_out,
   output logic [FLAG_W-1:0] got_flags_out,
   output logic done_out
);
   logic [4:0] cnt_q;
   // Select held past the sync delay
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         select_n_out <= 1'b1;
         cnt_q <= 5'h00;
         got_flags_out <= '0;
         done_out <= 1'b0;
      end else if (select_n_out && frame_req_in) begin
         select_n_out <= 1'b0;
         cnt_q <= 5'h06 + {1'b0, hold_in};
         done_out <= 1'b0;
      end else if (!select_n_out) begin
         if (cnt_q == 5'h00) begin
            select_n_out <= 1'b1;
            got_flags_out <= frame_flags_in;
            done_out <= 1'b1;
         end else begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top import cafl_pkg::*;;
   logic core_clk_in, arst_n_in, reg_wr_in, reg_rd_in, conv_done_in;
   logic supply_low_cmp_in, supply_high_cmp_in, conversion_start_select_n_in;
   logic [ADDR_W-1:0] reg_addr_in;
   logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
   logic [RES_W-1:0] conv_result_in;
   logic shared_alarm_output_pin_out, shared_alarm_output_pin_oe_n_out;
   logic [FLAG_W-1:0] frame_alarm_flags_out, got;
   logic [RES_W+SEL_W-1:0] stream_data_out;
   logic stream_valid_out, irq_out, frame_req, fdone, sel_e;
   logic [3:0] hold, fmask_e;
   int mismatches, n_compared, cyc;
   cafl_top u_cafl_top (.*);
   cafl_host_model u_cafl_host_model (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
      .frame_req_in(frame_req), .hold_in(hold), .frame_flags_in(frame_alarm_flags_out),
      .select_n_out(conversion_start_select_n_in), .got_flags_out(got), .done_out(fdone));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic nclk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic settle();
      @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      nclk(1);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      nclk(1);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      nclk(1);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      nclk(1);
      reg_rd_in <= 1'b0;
      #1;
      chk(reg_rdata_out, e);
   endtask
   task automatic sup(input logic l, input logic h);
      nclk(1);
      supply_low_cmp_in <= l;
      supply_high_cmp_in <= h;
      nclk(4);
   endtask
   // Flag read optional, so sticky bits can be kept
   task automatic conv(input logic [17:0] r, input logic [5:0] e, input logic rd_en);
      nclk(1);
      conv_done_in <= 1'b1;
      conv_result_in <= r;
      nclk(1);
      conv_done_in <= 1'b0;
      #1;
      chk(shared_alarm_output_pin_out, sel_e & (e[1] | e[3]));
      settle();
      chk(stream_valid_out, 1'b1);
      chk(stream_data_out, {r, e[3:0] & fmask_e});
      if (rd_en) rd(OFF_FLAGS, e);
   endtask
   task automatic frame(input logic [3:0] h, input logic [5:0] e);
      nclk(1);
      hold <= h;
      frame_req <= 1'b1;
      nclk(1);
      frame_req <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         settle();
         if (fdone) break;
      end
      chk(got, e);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(OFF_PIN_CTL, 0);
      rd(OFF_RST_PWR, 0);
      rd(OFF_HIGH_TH, 32'h0003_ffff);
      rd(OFF_LOW_TH, 0);
      rd(OFF_HYST, 0);
      rd(OFF_FMT_CTL, 0);
      rd(OFF_IRQ_MASK, 0);
      wr(OFF_FLAGS, 32'hffff_ffff);
      rd(OFF_FLAGS, 0);
      wr(8'h24, 32'hffff_ffff);
      rd(8'h24, 0);
      chk(shared_alarm_output_pin_oe_n_out, 1'b1);
      chk(irq_out, 1'b0);
      $display("reset done");
   endtask
   task automatic t_input();
      conv(18'h0_0100, 6'h00, 1'b1);
      conv(18'h0_0010, 6'h00, 1'b1);
      conv(18'h0_0101, 6'h13, 1'b1);
      conv(18'h0_00fc, 6'h13, 1'b1);
      conv(18'h0_00fb, 6'h00, 1'b1);
      conv(18'h0_000f, 6'h23, 1'b1);
      conv(18'h0_0014, 6'h23, 1'b1);
      conv(18'h0_0015, 6'h00, 1'b1);
      conv(18'h0_0101, 6'h13, 1'b0);
      conv(18'h0_00fb, 6'h01, 1'b1);
      rd(OFF_FLAGS, 0);
      wr(OFF_FMT_CTL, 32'h0000_000b);
      fmask_e = 4'h5;
      conv(18'h0_0101, 6'h13, 1'b1);
      wr(OFF_FMT_CTL, 32'h0000_0000);
      fmask_e = 4'h0;
      conv(18'h0_00fb, 6'h00, 1'b1);
      $display("input done");
   endtask
   task automatic t_supply();
      for (int i = 0; i < 2; i++) begin
         sup(i == 0, i == 1);
         conv(18'h0_0080, 6'h0c, 1'b1);
         sup(1'b0, 1'b0);
         conv(18'h0_0080, 6'h0c, 1'b1);
         conv(18'h0_0080, 6'h00, 1'b1);
      end
      $display("supply done");
   endtask
   task automatic t_disable();
      wr(OFF_RST_PWR, 32'h0000_0001);
      conv(18'h0_0101, 6'h00, 1'b1);
      sup(1'b1, 1'b0);
      wr(OFF_RST_PWR, 32'h0000_0002);
      conv(18'h0_0101, 6'h13, 1'b1);
      sup(1'b0, 1'b0);
      wr(OFF_RST_PWR, 32'h0000_0000);
      conv(18'h0_00fb, 6'h0c, 1'b1);
      conv(18'h0_00fb, 6'h00, 1'b1);
      $display("disable done");
   endtask
   task automatic t_irq();
      wr(OFF_IRQ_STAT, 32'h0000_0003);
      conv(18'h0_0101, 6'h13, 1'b1);
      chk(irq_out, 1'b0);
      rd(OFF_IRQ_STAT, 32'h0000_0001);
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      settle();
      chk(irq_out, 1'b1);
      wr(OFF_IRQ_STAT, 32'h0000_0003);
      settle();
      chk(irq_out, 1'b0);
      rd(OFF_IRQ_STAT, 0);
      conv(18'h0_00fb, 6'h00, 1'b1);
      $display("irq done");
   endtask
   // Other pin functions must release the pin yet keep the flags running
   task automatic t_pinsel();
      for (int i = 0; i < 4; i++) begin
         wr(OFF_PIN_CTL, (i + 2) % 4);
         sel_e = ((i + 2) % 4 == 1);
         settle();
         chk(shared_alarm_output_pin_oe_n_out, !sel_e);
         conv(18'h0_0101, 6'h13, 1'b1);
         conv(18'h0_00fb, 6'h00, 1'b1);
      end
      $display("pin select done");
   endtask
   task automatic t_frame();
      conv(18'h0_0101, 6'h13, 1'b0);
      frame(4'h0, 6'h13);
      rd(OFF_FLAGS, 6'h13);
      conv(18'h0_00fb, 6'h00, 1'b0);
      frame(4'h8, 6'h00);
      $display("frame done");
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      {arst_n_in, reg_wr_in, reg_rd_in, conv_done_in, frame_req} = '0;
      {supply_low_cmp_in, supply_high_cmp_in, sel_e} = '0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      conv_result_in = '0;
      hold = '0;
      fmask_e = 4'h0;
      nclk(10);
      arst_n_in <= 1'b1;
      t_reset();
      wr(OFF_PIN_CTL, 32'h0000_0001);
      wr(OFF_HIGH_TH, 32'h0000_0100);
      wr(OFF_LOW_TH, 32'h0000_0010);
      wr(OFF_HYST, 32'h0000_0004);
      wr(OFF_FMT_CTL, 32'h0000_001f);
      sel_e = 1'b1;
      fmask_e = 4'hf;
      t_input();
      t_supply();
      t_disable();
      t_irq();
      t_pinsel();
      t_frame();
      results();
   end
endmodule
